// file: logic/lpa_scan.sv
// Behaviour
// - Sweep starts on start pulse with clock
// - First pixel switch closes on clock
// - Advance one pixel until last read
// - Reading a pixel resets its photodiode
// - Array length parameter 128 to 2048, range not checked in code
`timescale 1ns/1ps
`include "lpa_params.svh"
module lpa_scan #(
	parameter int PIXELS = `LPA_PIXELS_DEFAULT,
	parameter int AW     = 12
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_srst,
	// Driver pulses
	input  wire logic          i_clk_pulse,
	input  wire logic          i_start,
	// Pixel address and status
	output logic               o_addr_on,
	output logic [AW-1:0]      o_addr,
	output logic               o_pix_reset,
	output logic               o_busy,
	output logic               o_eos
);
	lpa_pkg::lpa_state_e state_reg;
	lpa_pkg::lpa_state_e state_next;
	logic [AW-1:0]       addr_reg;
	logic [AW-1:0]       addr_next;
	logic                on_reg;
	logic                on_next;
	logic                eos_reg;
	logic                eos_next;
	logic                start_pend_reg;
	logic                start_pend_next;
	logic                clk_rise;

	localparam logic [AW-1:0] LAST = AW'(PIXELS - 1);

	lpa_edge u_edge (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_level (i_clk_pulse),
		.o_rise  (clk_rise)
	);

	always_comb begin
		state_next      = state_reg;
		addr_next       = addr_reg;
		on_next         = on_reg;
		eos_next        = 1'b0;
		start_pend_next = start_pend_reg;
		unique case (state_reg)
			lpa_pkg::LPA_IDLE: begin
				if (i_start) begin
					start_pend_next = 1'b1;
				end
				if (start_pend_reg && clk_rise) begin
					state_next      = lpa_pkg::LPA_SCAN;
					addr_next       = `LPA_ADDR_RST;
					on_next         = 1'b1;
					start_pend_next = 1'b0;
				end
			end
			lpa_pkg::LPA_SCAN: begin
				if (clk_rise) begin
					if (addr_reg == LAST) begin
						state_next = lpa_pkg::LPA_IDLE;
						on_next    = 1'b0;
						eos_next   = 1'b1;
					end else begin
						addr_next = addr_reg + AW'(1);
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_reg      <= lpa_pkg::LPA_IDLE;
			addr_reg       <= `LPA_ADDR_RST;
			on_reg         <= `LPA_RST_LOW;
			eos_reg        <= `LPA_RST_LOW;
			start_pend_reg <= `LPA_RST_LOW;
		end else begin
			state_reg      <= state_next;
			addr_reg       <= addr_next;
			on_reg         <= on_next;
			eos_reg        <= eos_next;
			start_pend_reg <= start_pend_next;
		end
	end

	assign o_addr_on   = on_reg;
	assign o_addr      = addr_reg;
	assign o_pix_reset = on_reg;
	assign o_busy      = on_reg;
	assign o_eos       = eos_reg;
endmodule // lpa_scan

// file: logic/lpa_params.svh
`ifndef LPA_PARAMS_SVH
`define LPA_PARAMS_SVH

// Array length bounds and default
`define LPA_PIXELS_MIN      128
`define LPA_PIXELS_MAX      2048
`define LPA_PIXELS_DEFAULT  2048
// Reset values
`define LPA_ADDR_RST        12'h000
`define LPA_RST_LOW         1'b0

`endif

// file: logic/lpa_pkg.sv
package lpa_pkg;
	typedef enum logic [0:0] {
		LPA_IDLE = 1'b0,
		LPA_SCAN = 1'b1
	} lpa_state_e;
endpackage

// file: logic/lpa_edge.sv
`timescale 1ns/1ps
`include "lpa_params.svh"
// Rising edge detector on a synchronous input
module lpa_edge (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// Level in, pulse out
	input  wire logic i_level,
	output logic      o_rise
);
	logic prev_reg;
	logic prev_next;
	logic rise_reg;
	logic rise_next;

	always_comb begin
		prev_next = i_level;
		rise_next = i_level & ~prev_reg;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			prev_reg <= `LPA_RST_LOW;
			rise_reg <= `LPA_RST_LOW;
		end else begin
			prev_reg <= prev_next;
			rise_reg <= rise_next;
		end
	end

	assign o_rise = rise_reg;
endmodule // lpa_edge

// file: testbench/lpa_scan_chk.sv
`timescale 1ns/1ps
module lpa_scan_chk#(int PIXELS=128,AW=12)(input wire logic i_clk,i_srst,i_clk_pulse,
	o_addr_on,o_pix_reset,o_busy,o_eos,input wire logic[AW-1:0]o_addr);
	default clocking@(posedge i_clk);endclocking
	default disable iff(i_srst);
	property p_go;$rose(o_addr_on)|->$past(i_clk_pulse,2)&&!$past(i_clk_pulse,3);endproperty
	a_go:assert property(p_go)else $error("start");
	property p_0;$rose(o_addr_on)|->o_addr==0;endproperty
	a_0:assert property(p_0)else $error("first");
	property p_inc;o_addr_on&&$past(o_addr_on)&&$changed(o_addr)|->o_addr==$past(o_addr)+1;
	endproperty
	a_inc:assert property(p_inc)else $error("step");
	property p_rs;o_pix_reset==o_addr_on&&o_busy==o_addr_on;endproperty
	a_rs:assert property(p_rs)else $error("reset");
	property p_end;$fell(o_addr_on)&&!$past(i_srst)|->o_eos&&$past(o_addr)==PIXELS-1;endproperty
	a_end:assert property(p_end)else $error("end");
	property p_eos1;o_eos|=>!o_eos&&!o_addr_on;endproperty
	a_eos1:assert property(p_eos1)else $error("eos");
endmodule // lpa_scan_chk
bind lpa_scan lpa_scan_chk#(.PIXELS(PIXELS),.AW(AW))u_chk(.*);

// file: testbench/lpa_drv.sv
`timescale 1ns/1ps
module lpa_drv(input wire logic i_clk,i_go,i_eos,input wire logic[2:0]i_half,
	output logic o_clk_pulse=0,o_start=0);
	logic[2:0]n=0;
	logic run=0;
	logic amp_rst=0;
	logic clamp=0;
	always@(negedge i_clk)begin
		n<=n>=i_half?3'h0:n+3'h1;
		if(n>=i_half)o_clk_pulse<=!o_clk_pulse;
		o_start<=i_go&&!run;
		run<=i_go&&!run||run&&!i_eos;
		amp_rst<=(n>=i_half)&&!o_clk_pulse;
		clamp<=amp_rst;
	end
endmodule // lpa_drv

// file: testbench/tb_lpa_scan.sv
`timescale 1ns/1ps
module tb_lpa_scan;
	localparam int P=128;
	logic i_clk=0,i_srst=1,go=0,cp,st,on,eos,lon;
	logic[2:0]h=0;
	logic[11:0]a,la;
	int bad_count=0,check_count=0,n,t=0;
	`define CK(x,y) begin check_count++;if((x)!==(y))begin bad_count++;\
		$display("Error %0t %h %h",$time,x,y);end end
	function logic[11:0]f_last;return 12'(P-1);endfunction
	always #12.5 i_clk=!i_clk;
	always@(posedge i_clk)if(++t>20000)begin bad_count++;finish_test;end
	lpa_drv d(.i_clk,.i_go(go),.i_eos(eos),.i_half(h),.o_clk_pulse(cp),.o_start(st));
	lpa_scan#(.PIXELS(P))uut(.i_clk,.i_srst,.i_clk_pulse(cp),.i_start(st),.o_addr_on(on),
		.o_addr(a),.o_pix_reset(),.o_busy(),.o_eos(eos));
	task finish_test;$display("checks %0d bad %0d",check_count,bad_count);
		if(bad_count==0&&check_count>0)$display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;endtask
	initial begin
		void'($urandom(33));
		repeat(4)@(negedge i_clk);
		i_srst=0;
		repeat(40)@(negedge i_clk);
		`CK(on,1'b0)
		$display("idle done");
		go=1;
		repeat(3)begin
			h=$urandom%7;
			n=0;
			la='1;
			lon=0;
			do begin @(negedge i_clk);if(on&&(!lon||a!==la))n++;la=a;lon=on;end while(!eos);
			`CK(n,P)
			`CK(la,f_last())
			$display("sweep done");
		end
		repeat(99)@(negedge i_clk);
		i_srst=1;
		@(negedge i_clk);
		i_srst=0;
		go=0;
		`CK(on,1'b0)
		$display("reset done");
		finish_test;
	end
endmodule // tb_lpa_scan
